/* File: shared/mmo_pkg.sv */
// constants, layouts and types shared by the memory map and options block
`default_nettype none

package mmo_pkg;

   // map register layout: ram page in the high digit, register page low
   typedef struct packed {
      logic [3:0] ram_pos;
      logic [3:0] reg_pos;
   } mmo_map_t;

   // options register layout, msb first
   typedef struct packed {
      logic       converter_power_up;
      logic       alt_clock_select;
      logic       interrupt_edge_only;
      logic       stop_recovery_delay_enable;
      logic       clock_monitor_enable;
      logic       unused;
      logic [1:0] watchdog_rate_select;
   } mmo_opt_t;

   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_STOP = 3'b010,
      ST_WAKE = 3'b100
   } mmo_stop_t;

   // apb byte offsets and program memory page
   localparam logic [11:0] MAP_OFF      = 12'h000;
   localparam logic [11:0] OPT_OFF      = 12'h004;
   localparam logic [11:0] STAT_OFF     = 12'h008;
   localparam logic [11:0] PCTL_OFF     = 12'h00c;
   localparam logic [11:0] PCTL_SEP_OFF = 12'h010;
   localparam logic [3:0]  PMEM_PAGE    = 4'h1;

   // values after reset
   localparam logic [7:0] MAP_RST  = 8'h01;
   localparam logic [7:0] OPT_RST  = 8'h10;
   localparam logic [7:0] PCTL_RST = 8'h00;
   localparam logic [7:0] PMEM_RST = 8'hff;

   // field masks and positions
   localparam logic [7:0] OPT_PROT_MASK = 8'h33;
   localparam logic [7:0] OPT_IMPL_MASK = 8'hfb;
   localparam int         PCTL_LATCH    = 5;
   localparam int         PCTL_PGM      = 0;

   // cycle counts, prescaler width and register block address width
   localparam logic [6:0]  WIN_CYCLES  = 7'h40;
   localparam logic [11:0] REC_LONG    = 12'hfa0;
   localparam logic [11:0] REC_SHORT   = 12'h004;
   localparam int          WDT_PRE_BITS = 15;
   localparam int          REG_BLK_BITS = 6;

endpackage : mmo_pkg

`default_nettype wire

/* File: design/mmo_wdt_prescale.sv */
// watchdog prescaler: fixed power-of-two divide then rate scaling
`default_nettype none

module mmo_wdt_prescale
   import mmo_pkg::*;
#(
   parameter int PRE_BITS = WDT_PRE_BITS
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [1:0] rate,
   // tick to the watchdog counter
   output logic            tick
);

   localparam int W = PRE_BITS + 6;

   logic [W-1:0] cnt_q;
   logic [W:0]   span;
   logic [W-1:0] mask;
   logic         wrap;

   // each rate step adds a divide by four on top of the fixed divide
   assign span = {{W{1'b0}}, 1'b1} << (PRE_BITS + 2 * int'(rate));
   assign mask = span[W-1:0] - {{(W-1){1'b0}}, 1'b1};
   assign wrap = (cnt_q & mask) == mask;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         tick <= run & wrap;
         if (run) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule : mmo_wdt_prescale

`default_nettype wire

/* File: design/mmo_top.sv */
// memory map decode, system options and program memory control
`default_nettype none

module mmo_top
   import mmo_pkg::*;
#(
   parameter int RAM_BYTES     = 256,
   parameter int PM_AW         = 4,
   parameter bit SEPARATE_PROG = 1'b0,
   parameter int PRE_BITS      = WDT_PRE_BITS
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // operating mode
   input  wire logic        special_mode,
   // cpu address decode
   input  wire logic [15:0] cpu_addr,
   output logic             reg_blk_sel,
   output logic             ram_sel,
   // stop mode
   input  wire logic        stop_enter,
   input  wire logic        wake_up,
   output logic             cpu_run,
   // external interrupt
   input  wire logic        irq_n,
   output logic             irq_req,
   // watchdog and clocking controls
   output logic             wdt_tick,
   output logic             pump_clk_alt,
   output logic             adc_clk_alt,
   output logic             adc_power_up,
   output logic             clock_mon_en,
   // program memory erase
   input  wire logic        uv_erase
);

   localparam int PM_DEPTH = 1 << PM_AW;
   localparam logic [11:0] LONG_M1  = REC_LONG - 12'h001;
   localparam logic [11:0] SHORT_M1 = REC_SHORT - 12'h001;

   mmo_map_t         map_q;
   mmo_opt_t         opt_q;
   mmo_stop_t        st_q;
   logic [6:0]       win_cnt_q;
   logic             map_done_q;
   logic             opt_done_q;
   logic [11:0]      rec_cnt_q;
   logic             rec_long_q;
   logic             irq_prev_q;
   logic             irq_req_q;
   logic [7:0]       pctl_q;
   logic [PM_AW-1:0] lat_addr_q;
   logic [7:0]       lat_data_q;
   logic [7:0]       pm_q [PM_DEPTH];
   logic [31:0]      prdata_q;

   // bus decode
   wire        wr       = psel & penable & pwrite;
   wire        rd_setup = psel & ~penable & ~pwrite;
   wire [11:0] pctl_off = SEPARATE_PROG ? PCTL_SEP_OFF : PCTL_OFF;
   wire        map_hit  = paddr == MAP_OFF;
   wire        opt_hit  = paddr == OPT_OFF;
   wire        stat_hit = paddr == STAT_OFF;
   wire        pctl_hit = paddr == pctl_off;
   wire        pm_hit   = paddr[11:8] == PMEM_PAGE && paddr[1:0] == 2'b00
                          && {2'b00, paddr[7:2]} < 8'(PM_DEPTH);
   wire        any_hit  = map_hit | opt_hit | stat_hit | pctl_hit | pm_hit;
   wire [PM_AW-1:0] pm_idx = paddr[2 +: PM_AW];

   // write protection window
   wire window_open = win_cnt_q < WIN_CYCLES;
   wire map_ok = special_mode | (window_open & ~map_done_q);
   wire opt_ok = special_mode | (window_open & ~opt_done_q);
   wire map_we = wr & map_hit & map_ok;
   wire opt_we = wr & opt_hit;

   // protected option bits keep their value once locked
   wire [7:0] opt_keep = opt_ok ? 8'h00 : OPT_PROT_MASK;
   wire [7:0] opt_new  = ((opt_q & opt_keep) | (pwdata[7:0] & ~opt_keep))
                         & OPT_IMPL_MASK;

   // program control: latch bit frozen while pgm set, pgm needs latch
   wire       pctl_we   = wr & pctl_hit;
   wire       latch_nxt = pctl_q[PCTL_PGM] ? pctl_q[PCTL_LATCH]
                          : pwdata[PCTL_LATCH];
   wire       pgm_nxt   = pctl_q[PCTL_LATCH] ? pwdata[PCTL_PGM]
                          : pctl_q[PCTL_PGM];
   wire       pgm_fire  = pctl_we & pgm_nxt & ~pctl_q[PCTL_PGM];
   wire       pm_lat_we = wr & pm_hit & pctl_q[PCTL_LATCH];
   wire [7:0] pctl_new  = {2'b00, latch_nxt, 4'h0, pgm_nxt};

   // cpu address decode
   wire reg_raw = cpu_addr[15:12] == map_q.reg_pos
                  && cpu_addr[11:REG_BLK_BITS] == '0;
   wire ram_raw = cpu_addr[15:12] == map_q.ram_pos
                  && {4'h0, cpu_addr[11:0]} < 16'(RAM_BYTES);
   assign reg_blk_sel = reg_raw;
   assign ram_sel     = ram_raw & ~reg_raw;

   // read mux
   wire [7:0] stat_rd = {3'b000, special_mode, st_q == ST_STOP,
                         opt_done_q, map_done_q, window_open};
   wire [7:0] pm_rd   = pctl_q[PCTL_LATCH] ? 8'h00 : pm_q[pm_idx];
   wire [7:0] rd_mux  = map_hit  ? map_q  :
                        opt_hit  ? opt_q  :
                        stat_hit ? stat_rd :
                        pctl_hit ? pctl_q :
                        pm_hit   ? pm_rd  : 8'h00;

   // zero-wait slave; read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~any_hit;
   assign prdata  = prdata_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= '0;
      end else if (rd_setup) begin
         prdata_q <= {24'h000000, rd_mux};
      end
   end

   // cycle counter saturates once the window has closed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         win_cnt_q <= '0;
      end else if (window_open) begin
         win_cnt_q <= win_cnt_q + 7'h01;
      end
   end

   // map register; done flag only matters in normal modes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         map_q      <= MAP_RST;
         map_done_q <= 1'b0;
      end else if (map_we) begin
         map_q      <= pwdata[7:0];
         map_done_q <= ~special_mode;
      end
   end

   // options register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opt_q      <= OPT_RST;
         opt_done_q <= 1'b0;
      end else if (opt_we) begin
         opt_q      <= opt_new;
         opt_done_q <= opt_done_q | (opt_ok & ~special_mode);
      end
   end

   assign pump_clk_alt = opt_q.alt_clock_select;
   assign adc_clk_alt  = opt_q.alt_clock_select;
   assign adc_power_up = opt_q.converter_power_up;
   assign clock_mon_en = opt_q.clock_monitor_enable;

   // stop recovery; the delay choice is frozen at wake so a special-mode
   // write during recovery cannot stretch or cut it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q       <= ST_RUN;
         rec_cnt_q  <= '0;
         rec_long_q <= 1'b0;
      end else begin
         case (st_q)
            ST_RUN: begin
               if (stop_enter) begin
                  st_q <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (wake_up) begin
                  st_q       <= ST_WAKE;
                  rec_long_q <= opt_q.stop_recovery_delay_enable;
                  rec_cnt_q  <= opt_q.stop_recovery_delay_enable
                                ? REC_LONG - 12'h001
                                : REC_SHORT - 12'h001;
               end
            end
            ST_WAKE: begin
               rec_cnt_q <= rec_cnt_q - 12'h001;
               if (rec_cnt_q == 12'h001) begin
                  st_q <= ST_RUN;
               end
            end
            default: begin
               st_q <= ST_RUN;
            end
         endcase
      end
   end

   assign cpu_run = st_q == ST_RUN;

   // external interrupt; the input is active low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_prev_q <= 1'b1;
         irq_req_q  <= 1'b0;
      end else begin
         irq_prev_q <= irq_n;
         irq_req_q  <= opt_q.interrupt_edge_only
                       ? (irq_prev_q & ~irq_n)
                       : ~irq_n;
      end
   end

   assign irq_req = irq_req_q;

   // program control register and address/data latch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pctl_q     <= PCTL_RST;
         lat_addr_q <= '0;
         lat_data_q <= PMEM_RST;
      end else begin
         if (pctl_we) begin
            pctl_q <= pctl_new;
         end
         if (pm_lat_we) begin
            lat_addr_q <= pm_idx;
            lat_data_q <= pwdata[7:0];
         end
      end
   end

   // program memory: erase gives ones, programming can only clear bits
   genvar gi;
   generate
      for (gi = 0; gi < PM_DEPTH; gi++) begin : g_pm
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               pm_q[gi] <= PMEM_RST;
            end else if (uv_erase) begin
               pm_q[gi] <= PMEM_RST;
            end else if (pgm_fire && lat_addr_q == PM_AW'(gi)) begin
               pm_q[gi] <= pm_q[gi] & lat_data_q;
            end
         end
      end
   endgenerate

   // watchdog clock stops with the oscillator in stop mode
   mmo_wdt_prescale #(
      .PRE_BITS (PRE_BITS)
   ) u_wdt_pre (
      .clk  (clk),
      .rst  (rst),
      .run  (cpu_run),
      .rate (opt_q.watchdog_rate_select),
      .tick (wdt_tick)
   );

   // helper: length of the recovery wait
   logic [11:0] wake_len_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_len_q <= '0;
      end else if (st_q == ST_WAKE) begin
         wake_len_q <= wake_len_q + 12'h001;
      end else begin
         wake_len_q <= '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_short_wake;
      st_q == ST_STOP && wake_up && !opt_q.stop_recovery_delay_enable;
   endsequence

   a_reg_block_base: assert property (
      cpu_addr == {map_q.reg_pos, 12'h000} |-> reg_blk_sel)
      else $error("register block base not decoded");
   a_ram_yields_reg: assert property (
      reg_blk_sel |-> !ram_sel)
      else $error("ram selected over register block");
   a_map_write_once: assert property (
      map_done_q && !special_mode && wr && map_hit |=> $stable(map_q))
      else $error("locked map register changed");
   a_opt_prot_lock: assert property (
      opt_done_q && !special_mode && opt_we
      |=> (opt_q & OPT_PROT_MASK) == ($past(opt_q) & OPT_PROT_MASK))
      else $error("locked option bits changed");
   a_late_write_refused: assert property (
      !window_open && !special_mode && opt_we
      |=> (opt_q & OPT_PROT_MASK) == ($past(opt_q) & OPT_PROT_MASK))
      else $error("option bits written after window");
   a_short_resume: assert property (
      s_short_wake |=> !cpu_run [*3] ##1 cpu_run)
      else $error("short stop recovery not four cycles");
   a_long_resume: assert property (
      $rose(cpu_run) && rec_long_q |-> wake_len_q == LONG_M1)
      else $error("long stop recovery length wrong");
   a_short_len: assert property (
      $rose(cpu_run) && !rec_long_q |-> wake_len_q == SHORT_M1)
      else $error("short stop recovery length wrong");
   a_unimpl_reads_zero: assert property (
      rd_setup && opt_hit |=> prdata[2] == 1'b0)
      else $error("unimplemented option bit read as one");
   a_irq_edge_pulse: assert property (
      opt_q.interrupt_edge_only && $past(opt_q.interrupt_edge_only)
      && irq_req |=> !irq_req)
      else $error("edge interrupt held as level");
   a_prog_only_clears: assert property (
      pgm_fire && !uv_erase
      |=> pm_q[lat_addr_q] == ($past(pm_q[lat_addr_q]) & lat_data_q))
      else $error("programming set a bit");

endmodule : mmo_top

`default_nettype wire

/* File: test/mmo_top_bench.sv */
// self-checking bench for the memory map and system options block
`default_nettype none

module mmo_top_bench
   import mmo_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        rd;
      logic        err;
      logic [31:0] d;
   } mmo_note_t;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        special_mode = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic        stop_enter = 1'b0;
   logic        wake_up = 1'b0;
   logic        irq_n = 1'b1;
   logic        uv_erase = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, reg_blk_sel, ram_sel, cpu_run, irq_req;
   logic        wdt_tick, pump_clk_alt, adc_clk_alt, adc_power_up;
   logic        clock_mon_en;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          irq_cnt = 0;
   logic [31:0] seed = 32'hec85fdc6;
   mmo_note_t   notes[$];
   mmo_note_t   cur;

   always #12.5 clk = ~clk;

   // short prescaler keeps the watchdog periods cheap to measure
   mmo_top #(.PRE_BITS(3)) u_mmo_top (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
      .cpu_addr(cpu_addr), .reg_blk_sel(reg_blk_sel), .ram_sel(ram_sel),
      .stop_enter(stop_enter), .wake_up(wake_up), .cpu_run(cpu_run),
      .irq_n(irq_n), .irq_req(irq_req), .wdt_tick(wdt_tick),
      .pump_clk_alt(pump_clk_alt), .adc_clk_alt(adc_clk_alt),
      .adc_power_up(adc_power_up), .clock_mon_en(clock_mon_en),
      .uv_erase(uv_erase)
   );

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one apb transfer; the expected answer is noted before it starts
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [7:0] e,
                       input logic err);
      notes.push_back('{~w, err, {24'h0, e}});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // monitor: every completed access consumes the oldest note
   always @(posedge clk) begin
      cycles++;
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         cur = notes.pop_front();
         chk("pslverr", pslverr, cur.err);
         if (cur.rd) chk("prdata", prdata, cur.d);
      end
      if (irq_req === 1'b1) irq_cnt++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic reset_dut();
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset_prdata", prdata, 32'h0);
      chk("reset_outs", {pready, pslverr, cpu_run, irq_req, wdt_tick},
          5'b10100);
   endtask : reset_dut

   task automatic dec(input logic [7:0] m, input logic [15:0] a);
      logic r;
      r = a[15:12] == m[3:0] && a[11:6] == 6'h0;
      @(posedge clk) cpu_addr <= a;
      @(negedge clk);
      chk("reg_blk_sel", reg_blk_sel, r);
      chk("ram_sel", ram_sel,
          !r && a[15:12] == m[7:4] && a[11:8] == 4'h0);
   endtask : dec

   task automatic dec_all(input logic [7:0] m);
      logic [31:0] v;
      logic [3:0]  pg;
      dec(m, {m[3:0], 12'h03f});
      dec(m, {m[3:0], 12'h040});
      dec(m, {m[7:4], 12'h0ff});
      dec(m, {m[7:4], 12'h100});
      for (int i = 0; i < 16; i++) begin
         v = rnd();
         pg = v[17] ? m[3:0] : (v[18] ? m[7:4] : v[15:12]);
         dec(m, {pg, v[16] ? {6'h0, v[5:0]} : v[11:0]});
      end
   endtask : dec_all

   task automatic wake(input int exp);
      int n;
      n = 0;
      @(posedge clk) stop_enter <= 1'b1;
      @(posedge clk) stop_enter <= 1'b0;
      @(posedge clk) wake_up <= 1'b1;
      @(negedge clk) chk("stopped", cpu_run, 1'b0);
      @(posedge clk) wake_up <= 1'b0;
      #1;
      while (cpu_run !== 1'b1 && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
      // the rule only promises roughly this many cycles
      chk("recovery", n >= exp - 1 && n <= exp + 1, 1'b1);
   endtask : wake

   task automatic irq(input logic edge_mode);
      int len;
      len = 2 + int'(rnd() % 8);
      @(negedge clk) irq_cnt = 0;
      @(posedge clk) irq_n <= 1'b0;
      repeat (len) @(posedge clk);
      irq_n <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("irq_req", 32'(irq_cnt), edge_mode ? 32'd1 : 32'(len));
   endtask : irq

   task automatic wdt(input int exp);
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (wdt_tick !== 1'b1 && n < 2000);
      end
      chk("wdt_period", 32'(n), 32'(exp));
   endtask : wdt

   initial begin
      reset_dut();
      xfer(1'b0, MAP_OFF, 8'h00, MAP_RST, 1'b0);
      xfer(1'b0, OPT_OFF, 8'h00, OPT_RST, 1'b0);
      xfer(1'b1, MAP_OFF, 8'h23, 8'h00, 1'b0);
      xfer(1'b1, OPT_OFF, 8'hff, 8'h00, 1'b0);
      @(negedge clk);
      chk("opt_outs", {adc_power_up, pump_clk_alt, adc_clk_alt,
          clock_mon_en}, 4'hf);
      xfer(1'b1, MAP_OFF, 8'h45, 8'h00, 1'b0);
      xfer(1'b1, OPT_OFF, 8'h00, 8'h00, 1'b0);
      xfer(1'b0, MAP_OFF, 8'h00, 8'h23, 1'b0);
      xfer(1'b0, OPT_OFF, 8'h00, 8'h33, 1'b0);
      chk("opt_outs", {pump_clk_alt, adc_clk_alt}, 2'b00);
      dec_all(8'h23);
      irq(1'b1);
      wdt(1 << 9);
      wake(4000);
      xfer(1'b1, 12'h020, 8'h55, 8'h00, 1'b1);
      xfer(1'b0, 12'h020, 8'h00, 8'h00, 1'b1);
      // second reset: map and protected option bit writes after the window must be ignored
      reset_dut();
      repeat (70) @(posedge clk);
      xfer(1'b1, OPT_OFF, 8'h00, 8'h00, 1'b0);
      xfer(1'b1, MAP_OFF, 8'h23, 8'h00, 1'b0);
      xfer(1'b0, OPT_OFF, 8'h00, 8'h10, 1'b0);
      xfer(1'b0, MAP_OFF, 8'h00, MAP_RST, 1'b0);
      dec_all(MAP_RST);
      irq(1'b0);
      wdt(8);
      @(posedge clk) special_mode <= 1'b1;
      xfer(1'b1, OPT_OFF, 8'h00, 8'h00, 1'b0);
      xfer(1'b1, OPT_OFF, 8'h05, 8'h00, 1'b0);
      xfer(1'b0, OPT_OFF, 8'h00, 8'h01, 1'b0);
      xfer(1'b0, STAT_OFF, 8'h00, 8'h10, 1'b0);
      wdt(32);
      wake(4);
      xfer(1'b1, MAP_OFF, 8'h22, 8'h00, 1'b0);
      xfer(1'b1, MAP_OFF, 8'h11, 8'h00, 1'b0);
      xfer(1'b0, MAP_OFF, 8'h00, 8'h11, 1'b0);
      dec_all(8'h11);
      @(posedge clk) uv_erase <= 1'b1;
      @(posedge clk) uv_erase <= 1'b0;
      xfer(1'b0, 12'h104, 8'h00, PMEM_RST, 1'b0);
      // second pass shows programming can only clear bits
      for (int i = 0; i < 2; i++) begin
         xfer(1'b1, PCTL_OFF, 8'h20, 8'h00, 1'b0);
         xfer(1'b1, 12'h104, i ? 8'ha5 : 8'h5a, 8'h00, 1'b0);
         xfer(1'b1, PCTL_OFF, 8'h21, 8'h00, 1'b0);
         xfer(1'b0, PCTL_OFF, 8'h00, 8'h21, 1'b0);
         xfer(1'b1, PCTL_OFF, 8'h00, 8'h00, 1'b0);
         xfer(1'b1, PCTL_OFF, 8'h00, 8'h00, 1'b0);
         xfer(1'b0, 12'h104, 8'h00, i ? 8'h00 : 8'h5a, 1'b0);
      end
      end_of_test();
   end
endmodule : mmo_top_bench

`default_nettype wire
